// ===== include/ffs_pkg.sv
// package of register map, field positions, timing counts and carriers for the fan supervisor
`default_nettype none
package ffs_pkg;
	// register offsets
	localparam logic [7:0] ADDR_PRIMARY_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_SECONDARY_CONFIG = 8'h01;
	localparam logic [7:0] ADDR_INT_STATUS_ONE = 8'h02;
	localparam logic [7:0] ADDR_INT_STATUS_TWO = 8'h03;
	localparam logic [7:0] ADDR_FACTORY_TEST = 8'h07;
	localparam logic [7:0] ADDR_FAN_ONE_SPEED = 8'h08;
	localparam logic [7:0] ADDR_FAN_TWO_SPEED = 8'h09;
	localparam logic [7:0] ADDR_FAN_ONE_LIMIT = 8'h10;
	localparam logic [7:0] ADDR_FAN_TWO_LIMIT = 8'h11;
	localparam logic [7:0] ADDR_FAN_ONE_CHAR = 8'h20;
	localparam logic [7:0] ADDR_FAN_TWO_CHAR = 8'h21;
	localparam logic [7:0] ADDR_FAN_SPEED_SETTING = 8'h22;
	localparam logic [7:0] ADDR_FAN_FILTER_SETTING = 8'h23;
	localparam logic [7:0] ADDR_LOCAL_TEMP_MIN_RANGE = 8'h24;
	localparam logic [7:0] ADDR_REMOTE_ONE_TEMP_MIN_RANGE = 8'h25;
	localparam logic [7:0] ADDR_REMOTE_TWO_TEMP_MIN_RANGE = 8'h26;
	localparam logic [7:0] ADDR_DEVICE_IDENT = 8'h3d;
	localparam logic [7:0] ADDR_MAKER_IDENT = 8'h3e;
	localparam logic [7:0] ADDR_BEHAVIOR_REVISION = 8'h3f;

	// reset values
	localparam logic [7:0] RST_PRIMARY_CONFIG = 8'h90;
	localparam logic [7:0] RST_SECONDARY_CONFIG = 8'h7f;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_FAN_CHAR = 8'h5d;
	localparam logic [7:0] RST_FAN_SPEED_SETTING = 8'h55;
	localparam logic [7:0] RST_FAN_FILTER_SETTING = 8'h50;
	localparam logic [7:0] RST_LOCAL_TEMP_MIN_RANGE = 8'h41;
	localparam logic [7:0] RST_REMOTE_TEMP_MIN_RANGE = 8'h61;
	localparam logic [7:0] RST_TACH_LIMIT = 8'hff;
	localparam logic [7:0] RST_FAN_SPEED = 8'h00;
	localparam logic [7:0] RST_BEHAVIOR = 8'h00;

	// identity values: arbitrary, not tied to any part
	localparam logic [7:0] DEVICE_IDENT_VALUE = 8'h5a;
	localparam logic [7:0] MAKER_IDENT_VALUE = 8'h3c;
	localparam logic [3:0] REVISION_VALUE = 4'h1;

	// field positions
	localparam int MONITOR_BIT = 0;
	localparam int ALERT_ENABLE_BIT = 1;
	localparam int FAULT_ENABLE_BIT = 4;
	localparam int TACH_ENABLE_BIT = 2;
	localparam int FAN_FAULT_STATUS_BIT = 1;
	localparam int THERM_TO_FAN_BIT = 7;
	localparam int RANGE_MSB = 7;
	localparam int RANGE_LSB = 6;

	// failure counting
	localparam int NUM_FANS = 2;
	localparam logic [2:0] FAULT_FAIL_COUNT = 3'h5;
	localparam logic [7:0] SPEED_MAX = 8'hff;

	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int TACH_OSC_HZ = 11_250;
	localparam int SPINUP_MS = 2000;
	localparam int OSC_DIV_CYCLES = CLK_HZ / TACH_OSC_HZ;
	localparam int SPINUP_CYCLES = (CLK_HZ / 1000) * SPINUP_MS;

	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ffs_reg_req_s;

	typedef enum logic [1:0] {
		MEAS_IDLE,
		MEAS_ARM,
		MEAS_COUNT
	} ffs_meas_e;
endpackage
`default_nettype wire

// ===== logic/ffs_tach_meter.sv
// per-fan tach period meter with saturating 8-bit count
`default_nettype none
module ffs_tach_meter (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// control
	input wire logic i_enable,
	input wire logic [1:0] i_range,
	// sense pin
	input wire logic i_speed_sense_in,
	// result
	output logic o_done,
	output logic [7:0] o_count
);
	import ffs_pkg::*;

	logic sense_meta;
	logic sense_sync;
	logic sense_prev;
	logic rise;
	logic [12:0] presc;
	logic [12:0] presc_limit;
	logic tick;
	logic [1:0] edges;
	logic [7:0] cnt;
	ffs_meas_e state;

	// pin passes two flops; the edge detector compares the second one with a third, delayed copy
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sense_meta <= 1'b1;
			sense_sync <= 1'b1;
			sense_prev <= 1'b1;
		end else begin
			sense_meta <= i_speed_sense_in;
			sense_sync <= sense_meta;
			sense_prev <= sense_sync;
		end
	end
	assign rise = sense_sync & ~sense_prev;

	// range field divides the oscillator by 1, 2, 4 or 8
	assign presc_limit = 13'(OSC_DIV_CYCLES << i_range);
	assign tick = (presc >= presc_limit - 13'h1);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !i_enable || tick) begin
			presc <= 13'h0;
		end else begin
			presc <= presc + 13'h1;
		end
	end

	// start counting at the second rising edge, stop at the fourth
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= MEAS_IDLE;
			edges <= 2'h0;
			cnt <= 8'h0;
			o_done <= 1'b0;
			o_count <= 8'h0;
		end else begin
			o_done <= 1'b0;
			unique case (state)
				MEAS_IDLE: begin
					edges <= 2'h0;
					cnt <= 8'h0;
					if (i_enable) begin
						state <= MEAS_ARM;
					end
				end
				MEAS_ARM: begin
					if (!i_enable) begin
						state <= MEAS_IDLE;
					end else if (rise && edges == 2'h1) begin
						state <= MEAS_COUNT;
						edges <= 2'h0;
						cnt <= 8'h0;
					end else if (rise) begin
						edges <= edges + 2'h1;
					end else if (tick && cnt == SPEED_MAX) begin
						// fewer than two tach edges: stalled fan reads full scale
						o_done <= 1'b1;
						o_count <= SPEED_MAX;
						state <= MEAS_IDLE;
					end else if (tick) begin
						cnt <= cnt + 8'h1;
					end
				end
				MEAS_COUNT: begin
					if (!i_enable) begin
						state <= MEAS_IDLE;
					end else if (rise && edges == 2'h1) begin
						o_done <= 1'b1;
						o_count <= cnt;
						state <= MEAS_IDLE;
					end else if (tick && cnt == SPEED_MAX) begin
						o_done <= 1'b1;
						o_count <= SPEED_MAX;
						state <= MEAS_IDLE;
					end else begin
						if (rise) begin
							edges <= edges + 2'h1;
						end
						if (tick) begin
							cnt <= cnt + 8'h1;
						end
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== logic/ffs_spinup.sv
// spin-up interval timer, restarted by each trigger
`default_nettype none
module ffs_spinup #(
	parameter int SPINUP_CYCLES = 20_000_000
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// control
	input wire logic i_start,
	// status
	output logic o_busy
);
	import ffs_pkg::*;

	logic [31:0] remain;

	// a new failure during a spin-up restarts the full interval
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			remain <= 32'h0;
		end else if (i_start) begin
			remain <= 32'(SPINUP_CYCLES);
		end else if (remain != 32'h0) begin
			remain <= remain - 32'h1;
		end
	end
	assign o_busy = (remain != 32'h0);
endmodule
`default_nettype wire

// ===== logic/ffs_fan_fault_supervisor.sv
// fan failure supervisor: register map, tach limit checks, alert, spin-up and fault pin
`default_nettype none
module ffs_fan_fault_supervisor #(
	parameter int SPINUP_CYCLES = ffs_pkg::SPINUP_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// register port
	input wire ffs_pkg::ffs_reg_req_s i_reg,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	// fan sense and drive
	input wire logic [1:0] i_speed_sense_in,
	input wire logic [1:0] i_fan_drive_normal,
	output logic [1:0] o_fan_drive,
	// open-drain fault pin
	output logic o_fan_fault_n_out,
	output logic o_fan_fault_n_oe,
	// open-drain alert pin
	output logic o_alert_n_out,
	output logic o_alert_n_oe,
	// configuration seen by the rest of the device
	output logic o_therm_to_fan_en
);
	import ffs_pkg::*;

	logic [7:0] primary_config;
	logic [7:0] secondary_config;
	logic [7:0] interrupt_status_one;
	logic [7:0] interrupt_status_two;
	logic [7:0] fan_characteristics [NUM_FANS];
	logic [7:0] fan_speed_setting;
	logic [7:0] fan_filter_setting;
	logic [7:0] local_temp_min_range;
	logic [7:0] remote_one_temp_min_range;
	logic [7:0] remote_two_temp_min_range;
	logic [7:0] tach_limit [NUM_FANS];
	logic [7:0] fan_speed [NUM_FANS];
	logic therm_to_fan;
	logic [2:0] fail_count [NUM_FANS];
	logic [NUM_FANS-1:0] meas_done;
	logic [7:0] meas_count [NUM_FANS];
	logic [NUM_FANS-1:0] fail_evt;
	logic [NUM_FANS-1:0] spin_busy;
	logic [NUM_FANS-1:0] fan_failed;
	logic wr_one;
	logic wr_two;
	logic rd_one;
	logic rd_two;
	logic [7:0] next_rd_data;

	function automatic logic hit(input ffs_reg_req_s req, input logic [7:0] addr);
		hit = req.addr == addr;
	endfunction

	assign wr_one = i_reg.wr && hit(i_reg, ADDR_INT_STATUS_ONE);
	assign wr_two = i_reg.wr && hit(i_reg, ADDR_INT_STATUS_TWO);
	assign rd_one = i_reg.rd && hit(i_reg, ADDR_INT_STATUS_ONE);
	assign rd_two = i_reg.rd && hit(i_reg, ADDR_INT_STATUS_TWO);

	// configuration registers
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			primary_config <= RST_PRIMARY_CONFIG;
			secondary_config <= RST_SECONDARY_CONFIG;
			fan_speed_setting <= RST_FAN_SPEED_SETTING;
			fan_filter_setting <= RST_FAN_FILTER_SETTING;
			local_temp_min_range <= RST_LOCAL_TEMP_MIN_RANGE;
			remote_one_temp_min_range <= RST_REMOTE_TEMP_MIN_RANGE;
			remote_two_temp_min_range <= RST_REMOTE_TEMP_MIN_RANGE;
			therm_to_fan <= RST_BEHAVIOR[THERM_TO_FAN_BIT];
		end else if (i_reg.wr) begin
			unique case (i_reg.addr)
				ADDR_PRIMARY_CONFIG: primary_config <= i_reg.wdata;
				ADDR_SECONDARY_CONFIG: secondary_config <= i_reg.wdata;
				ADDR_FAN_SPEED_SETTING: fan_speed_setting <= i_reg.wdata;
				ADDR_FAN_FILTER_SETTING: fan_filter_setting <= i_reg.wdata;
				ADDR_LOCAL_TEMP_MIN_RANGE: local_temp_min_range <= i_reg.wdata;
				ADDR_REMOTE_ONE_TEMP_MIN_RANGE: remote_one_temp_min_range <= i_reg.wdata;
				ADDR_REMOTE_TWO_TEMP_MIN_RANGE: remote_two_temp_min_range <= i_reg.wdata;
				ADDR_BEHAVIOR_REVISION: therm_to_fan <= i_reg.wdata[THERM_TO_FAN_BIT];
				default: begin
				end
			endcase
		end
	end
	assign o_therm_to_fan_en = therm_to_fan;

	// per-fan channel: meter, limit check, failure count, spin-up
	genvar f;
	generate
		for (f = 0; f < NUM_FANS; f++) begin : g_fan
			ffs_tach_meter u_meter (
				.i_clk(i_clk),
				.i_sys_rst(i_sys_rst),
				.i_enable(primary_config[MONITOR_BIT] & secondary_config[TACH_ENABLE_BIT + f]),
				.i_range(fan_characteristics[f][RANGE_MSB:RANGE_LSB]),
				.i_speed_sense_in(i_speed_sense_in[f]),
				.o_done(meas_done[f]),
				.o_count(meas_count[f])
			);

			// the same stretch for both fans, counted on the device clock
			ffs_spinup #(
				.SPINUP_CYCLES(SPINUP_CYCLES)
			) u_spin (
				.i_clk(i_clk),
				.i_sys_rst(i_sys_rst),
				.i_start(fail_evt[f]),
				.o_busy(spin_busy[f])
			);

			// strictly greater; a limit of 0xfe catches only a full-scale reading, from a stalled fan or a saturated count
			assign fail_evt[f] = meas_done[f] && (meas_count[f] > tach_limit[f]);

			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					tach_limit[f] <= RST_TACH_LIMIT;
					fan_characteristics[f] <= RST_FAN_CHAR;
				end else if (i_reg.wr) begin
					if (hit(i_reg, ADDR_FAN_ONE_LIMIT + 8'(f))) begin
						tach_limit[f] <= i_reg.wdata;
					end
					if (hit(i_reg, ADDR_FAN_ONE_CHAR + 8'(f))) begin
						fan_characteristics[f] <= i_reg.wdata;
					end
				end
			end

			// a fresh measurement overrides a software write in the same cycle
			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					fan_speed[f] <= RST_FAN_SPEED;
				end else if (meas_done[f]) begin
					fan_speed[f] <= meas_count[f];
				end else if (i_reg.wr && hit(i_reg, ADDR_FAN_ONE_SPEED + 8'(f))) begin
					fan_speed[f] <= i_reg.wdata;
				end
			end

			// count saturates at five so the fault holds until a passing reading
			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					fail_count[f] <= 3'h0;
				end else if (fail_evt[f] && fail_count[f] != FAULT_FAIL_COUNT) begin
					fail_count[f] <= fail_count[f] + 3'h1;
				end else if (meas_done[f] && !fail_evt[f]) begin
					fail_count[f] <= 3'h0;
				end
			end

			assign fan_failed[f] = (fail_count[f] == FAULT_FAIL_COUNT);

			// forced high during spin-up, including after the fault is raised
			assign o_fan_drive[f] = spin_busy[f] | i_fan_drive_normal[f];
		end
	endgenerate

	// sticky fan fault flags; a failure landing on the clearing read wins
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			interrupt_status_one <= RST_STATUS;
		end else if (fail_evt[0]) begin
			interrupt_status_one[FAN_FAULT_STATUS_BIT] <= 1'b1;
		end else if (rd_one) begin
			interrupt_status_one <= RST_STATUS;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			interrupt_status_two <= RST_STATUS;
		end else if (fail_evt[1]) begin
			interrupt_status_two[FAN_FAULT_STATUS_BIT] <= 1'b1;
		end else if (rd_two) begin
			interrupt_status_two <= RST_STATUS;
		end
	end

	// alert: low while any flag is pending and the alert is enabled
	assign o_alert_n_out = 1'b0;
	assign o_alert_n_oe = primary_config[ALERT_ENABLE_BIT]
		& ((interrupt_status_one | interrupt_status_two) != 8'h00);

	// fault pin only ever pulls low; released otherwise
	assign o_fan_fault_n_out = 1'b0;
	assign o_fan_fault_n_oe = primary_config[FAULT_ENABLE_BIT] & (|fan_failed);

	// read mux; the factory test location and unmapped offsets read zero
	always_comb begin
		next_rd_data = 8'h00;
		unique case (i_reg.addr)
			ADDR_PRIMARY_CONFIG: next_rd_data = primary_config;
			ADDR_SECONDARY_CONFIG: next_rd_data = secondary_config;
			ADDR_INT_STATUS_ONE: next_rd_data = interrupt_status_one;
			ADDR_INT_STATUS_TWO: next_rd_data = interrupt_status_two;
			ADDR_FACTORY_TEST: next_rd_data = 8'h00;
			ADDR_FAN_ONE_SPEED: next_rd_data = fan_speed[0];
			ADDR_FAN_TWO_SPEED: next_rd_data = fan_speed[1];
			ADDR_FAN_ONE_LIMIT: next_rd_data = tach_limit[0];
			ADDR_FAN_TWO_LIMIT: next_rd_data = tach_limit[1];
			ADDR_FAN_ONE_CHAR: next_rd_data = fan_characteristics[0];
			ADDR_FAN_TWO_CHAR: next_rd_data = fan_characteristics[1];
			ADDR_FAN_SPEED_SETTING: next_rd_data = fan_speed_setting;
			ADDR_FAN_FILTER_SETTING: next_rd_data = fan_filter_setting;
			ADDR_LOCAL_TEMP_MIN_RANGE: next_rd_data = local_temp_min_range;
			ADDR_REMOTE_ONE_TEMP_MIN_RANGE: next_rd_data = remote_one_temp_min_range;
			ADDR_REMOTE_TWO_TEMP_MIN_RANGE: next_rd_data = remote_two_temp_min_range;
			ADDR_DEVICE_IDENT: next_rd_data = DEVICE_IDENT_VALUE;
			ADDR_MAKER_IDENT: next_rd_data = MAKER_IDENT_VALUE;
			ADDR_BEHAVIOR_REVISION: next_rd_data = {therm_to_fan, 3'h0, REVISION_VALUE};
			default: next_rd_data = 8'h00;
		endcase
	end

	// status writes are ignored: the flags only clear on a read
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_reg.rd;
			if (i_reg.rd) begin
				o_rd_data <= next_rd_data;
			end
		end
	end

	// write strobes to read-only status are decoded only to be dropped
	logic unused_ok;
	assign unused_ok = wr_one | wr_two;
endmodule
`default_nettype wire

// ===== verif/ffs_fan_fault_supervisor_assertions.sv
// port-level checker for the fan fault supervisor
`default_nettype none
module ffs_fan_fault_supervisor_assertions (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// register port
	input wire ffs_pkg::ffs_reg_req_s i_reg,
	input wire logic [7:0] o_rd_data,
	input wire logic o_rd_valid,
	// fan sense and drive
	input wire logic [1:0] i_speed_sense_in,
	input wire logic [1:0] i_fan_drive_normal,
	input wire logic [1:0] o_fan_drive,
	// pins
	input wire logic o_fan_fault_n_out,
	input wire logic o_fan_fault_n_oe,
	input wire logic o_alert_n_out,
	input wire logic o_alert_n_oe,
	input wire logic o_therm_to_fan_en
);
	import ffs_pkg::*;
	logic fault_en;
	logic alert_en;
	logic alert_q;
	logic fault_q;
	logic [3:0] rises;
	logic [3:0] alerts_seen;
	// shadow of the enables so pin behaviour is judged from the ports alone
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			fault_en <= RST_PRIMARY_CONFIG[FAULT_ENABLE_BIT];
			alert_en <= RST_PRIMARY_CONFIG[ALERT_ENABLE_BIT];
		end else if (i_reg.wr && i_reg.addr == ADDR_PRIMARY_CONFIG) begin
			fault_en <= i_reg.wdata[FAULT_ENABLE_BIT];
			alert_en <= i_reg.wdata[ALERT_ENABLE_BIT];
		end
	end
	always_ff @(posedge i_clk) begin
		alert_q <= o_alert_n_oe;
		fault_q <= o_fan_fault_n_oe;
	end
	// alert rises since the last recovery; a disable of the pin is not a recovery
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || (fault_q && !o_fan_fault_n_oe && fault_en)) begin
			rises <= 4'h0;
		end else if (alerts_seen != rises && rises != 4'hf) begin
			rises <= alerts_seen;
		end
	end
	assign alerts_seen = rises + {3'h0, o_alert_n_oe && !alert_q};
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_fault_low;
		o_fan_fault_n_out == 1'b0;
	endproperty
	a_fault_low: assert property (p_fault_low) else $error("fault pin value not low");
	property p_alert_low;
		o_alert_n_out == 1'b0;
	endproperty
	a_alert_low: assert property (p_alert_low) else $error("alert pin value not low");
	property p_fault_gated;
		o_fan_fault_n_oe |-> fault_en;
	endproperty
	a_fault_gated: assert property (p_fault_gated) else $error("fault pin on while off");
	property p_fault_after_five;
		$rose(o_fan_fault_n_oe) && alert_en |-> alerts_seen >= 4'h5;
	endproperty
	a_fault_after_five: assert property (p_fault_after_five) else $error("early fault");
	property p_alert_gated;
		o_alert_n_oe |-> alert_en;
	endproperty
	a_alert_gated: assert property (p_alert_gated) else $error("alert while disabled");
	property p_alert_holds;
		o_alert_n_oe && !i_reg.rd && !i_reg.wr |=> o_alert_n_oe;
	endproperty
	a_alert_holds: assert property (p_alert_holds) else $error("alert dropped unread");
	property p_spinup;
		$rose(o_alert_n_oe) |-> ##[0:2] (|o_fan_drive) [*8];
	endproperty
	a_spinup: assert property (p_spinup) else $error("no spin-up after failure");
	property p_drive_on_fault;
		$rose(o_fan_fault_n_oe) && $stable(fault_en) |-> ##[0:2] (|o_fan_drive);
	endproperty
	a_drive_on_fault: assert property (p_drive_on_fault) else $error("no drive at fault");
	property p_dev_id;
		i_reg.rd && i_reg.addr == ADDR_DEVICE_IDENT |=> o_rd_data == DEVICE_IDENT_VALUE;
	endproperty
	a_dev_id: assert property (p_dev_id) else $error("device id wrong");
	property p_maker_id;
		i_reg.rd && i_reg.addr == ADDR_MAKER_IDENT |=> o_rd_data == MAKER_IDENT_VALUE;
	endproperty
	a_maker_id: assert property (p_maker_id) else $error("maker id wrong");
	property p_revision;
		i_reg.rd && i_reg.addr == ADDR_BEHAVIOR_REVISION |=> o_rd_data[3:0] == REVISION_VALUE;
	endproperty
	a_revision: assert property (p_revision) else $error("revision wrong");
	property p_therm_en;
		i_reg.wr && i_reg.addr == ADDR_BEHAVIOR_REVISION
			|=> o_therm_to_fan_en == $past(i_reg.wdata[THERM_TO_FAN_BIT]);
	endproperty
	a_therm_en: assert property (p_therm_en) else $error("therm enable not taken");
endmodule
bind ffs_fan_fault_supervisor ffs_fan_fault_supervisor_assertions
	ffs_fan_fault_supervisor_assertions_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg(i_reg),
	.o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_speed_sense_in(i_speed_sense_in),
	.i_fan_drive_normal(i_fan_drive_normal), .o_fan_drive(o_fan_drive),
	.o_fan_fault_n_out(o_fan_fault_n_out), .o_fan_fault_n_oe(o_fan_fault_n_oe),
	.o_alert_n_out(o_alert_n_out), .o_alert_n_oe(o_alert_n_oe),
	.o_therm_to_fan_en(o_therm_to_fan_en));
`default_nettype wire

// ===== verif/ffs_fan_model.sv
// behavioural pair of fans giving tach pulses at a fixed period
`default_nettype none
module ffs_fan_model #(
	parameter int PERIOD_NS = 177_600
) (
	// spin control from the bench
	input wire logic [1:0] i_spin,
	// tach lines toward the device
	output logic [1:0] o_speed_sense
);
	timeunit 1ns;
	timeprecision 1ns;
	// a stopped fan leaves its tach to the pull-up; fan two lags a quarter period
	initial begin
		o_speed_sense = 2'b11;
		forever begin
			#(PERIOD_NS / 4);
			o_speed_sense[0] = i_spin[0] ? ~o_speed_sense[0] : 1'b1;
			#(PERIOD_NS / 4);
			o_speed_sense[1] = i_spin[1] ? ~o_speed_sense[1] : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== verif/ffs_fan_fault_supervisor_tb.sv
// self-checking bench for the fan fault supervisor
`default_nettype none
module ffs_fan_fault_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ffs_pkg::*;
	localparam int SPIN = 50;
	// a fan result repeats every four tach periods of the model, a little over 7100 cycles
	localparam int MEAS_WAIT = 7200;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	ffs_reg_req_s i_reg = '0;
	logic [1:0] i_fan_drive_normal = 2'b00;
	logic [1:0] sense;
	logic [7:0] o_rd_data;
	logic o_rd_valid;
	logic [1:0] o_fan_drive;
	logic o_fan_fault_n_out;
	logic o_fan_fault_n_oe;
	logic o_alert_n_out;
	logic o_alert_n_oe;
	logic o_therm_to_fan_en;
	logic fault_pin_n;
	int fail_count = 0;
	int samples_checked = 0;
	// board pull-up on the open-drain fault line
	assign fault_pin_n = o_fan_fault_n_oe ? o_fan_fault_n_out : 1'b1;
	always #50 i_clk = ~i_clk;
	ffs_fan_model ffs_fan_model_i (.i_spin(2'b11), .o_speed_sense(sense));
	ffs_fan_fault_supervisor #(.SPINUP_CYCLES(SPIN)) ffs_fan_fault_supervisor_i (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg(i_reg), .o_rd_data(o_rd_data),
		.o_rd_valid(o_rd_valid), .i_speed_sense_in(sense),
		.i_fan_drive_normal(i_fan_drive_normal), .o_fan_drive(o_fan_drive),
		.o_fan_fault_n_out(o_fan_fault_n_out), .o_fan_fault_n_oe(o_fan_fault_n_oe),
		.o_alert_n_out(o_alert_n_out), .o_alert_n_oe(o_alert_n_oe),
		.o_therm_to_fan_en(o_therm_to_fan_en));
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1 i_reg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		#1 i_reg = '0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		#1 i_reg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		#1 i_reg = '0;
		d = o_rd_data;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		reg_rd(a, d);
		check($sformatf("reg %h", a), {o_rd_valid, d}, {1'b1, exp});
	endtask
	task automatic wait_alert();
		int n;
		n = 0;
		while (o_alert_n_oe !== 1'b1 && n < 20000) begin
			@(posedge i_clk);
			#1 n++;
		end
	endtask
	task automatic t_reset_values();
		logic [7:0] a [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h20, 8'h21,
			8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h3d, 8'h3e, 8'h50};
		logic [7:0] e [16] = '{8'h90, 8'h7f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h5d, 8'h5d,
			8'h55, 8'h50, 8'h41, 8'h61, 8'h61, DEVICE_IDENT_VALUE, MAKER_IDENT_VALUE, 8'h00};
		for (int i = 0; i < 16; i++) begin
			chk_rd(a[i], e[i]);
		end
		check("fault_oe", {8'h0, o_fan_fault_n_oe}, 9'h0);
		reg_wr(ADDR_DEVICE_IDENT, 8'h00);
		chk_rd(ADDR_DEVICE_IDENT, DEVICE_IDENT_VALUE);
		reg_wr(ADDR_BEHAVIOR_REVISION, 8'hff);
		check("therm_en", {8'h0, o_therm_to_fan_en}, 9'h1);
		chk_rd(ADDR_BEHAVIOR_REVISION, {1'b1, RST_BEHAVIOR[6:4], REVISION_VALUE});
		reg_wr(ADDR_BEHAVIOR_REVISION, 8'h00);
		check("therm_en", {8'h0, o_therm_to_fan_en}, 9'h0);
	endtask
	task automatic t_monitor_off();
		reg_wr(ADDR_FAN_ONE_CHAR, 8'h1d);
		reg_wr(ADDR_FAN_ONE_LIMIT, 8'h01);
		reg_wr(ADDR_PRIMARY_CONFIG, 8'h92);
		repeat (12000) @(posedge i_clk);
		#1 check("alert_oe", {8'h0, o_alert_n_oe}, 9'h0);
		chk_rd(ADDR_FAN_ONE_SPEED, RST_FAN_SPEED);
	endtask
	task automatic t_fail_sequence();
		reg_wr(ADDR_PRIMARY_CONFIG, 8'h93);
		for (int k = 1; k <= 6; k++) begin
			wait_alert();
			check("alert_oe", {8'h0, o_alert_n_oe}, 9'h1);
			repeat (3) @(posedge i_clk);
			#1 check("drive", {7'h0, o_fan_drive}, 9'h1);
			check("fault_pin", {8'h0, fault_pin_n}, {8'h0, k < 5});
			// reading the status is how the processor acknowledges
			chk_rd(ADDR_INT_STATUS_ONE, 8'h02);
			check("alert_oe", {8'h0, o_alert_n_oe}, 9'h0);
			repeat (SPIN + 10) @(posedge i_clk);
			#1 check("drive", {7'h0, o_fan_drive}, 9'h0);
			if (k == 5) begin
				reg_wr(ADDR_PRIMARY_CONFIG, 8'h83);
				check("fault_oe", {8'h0, o_fan_fault_n_oe}, 9'h0);
				reg_wr(ADDR_PRIMARY_CONFIG, 8'h93);
				check("fault_oe", {8'h0, o_fan_fault_n_oe}, 9'h1);
			end
		end
		chk_rd(ADDR_INT_STATUS_TWO, 8'h00);
	endtask
	task automatic t_recover();
		int n;
		logic [7:0] spd;
		n = 0;
		i_fan_drive_normal = 2'b10;
		// the model's reading never changes, so a limit equal to it must pass
		reg_rd(ADDR_FAN_ONE_SPEED, spd);
		reg_wr(ADDR_FAN_ONE_LIMIT, spd);
		while (o_fan_fault_n_oe !== 1'b0 && n < 20000) begin
			@(posedge i_clk);
			#1 n++;
		end
		check("fault_oe", {8'h0, o_fan_fault_n_oe}, 9'h0);
		repeat (SPIN + 10) @(posedge i_clk);
		#1 check("drive", {7'h0, o_fan_drive}, 9'h2);
		// one below the reading fails; a fresh run of failures starts from zero
		reg_wr(ADDR_FAN_ONE_LIMIT, spd - 8'h1);
		reg_wr(ADDR_FAN_TWO_LIMIT, 8'h00);
		repeat (MEAS_WAIT) @(posedge i_clk);
		#1 check("fault_pin", {8'h0, fault_pin_n}, 9'h1);
		chk_rd(ADDR_INT_STATUS_ONE, 8'h02);
		chk_rd(ADDR_INT_STATUS_TWO, 8'h02);
	endtask
	task automatic end_sim();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#(100_000 * 100);
		fail_count++;
		end_sim();
	end
	// the factory test register is never touched; one unmapped place, 0x50, is read for zero
	initial begin
		repeat (16) @(posedge i_clk);
		#1 i_sys_rst = 1'b0;
		t_reset_values();
		t_monitor_off();
		t_fail_sequence();
		t_recover();
		end_sim();
	end
endmodule
`default_nettype wire
